/* File: rtl/serial_pll_divider_core.sv */
`timescale 1ns/1ps
module serial_pll_divider_core (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic serial_data,
    input wire logic shift_clock,
    input wire logic load_strobe,
    input wire logic phase_sense_select,
    input wire logic osc_in,
    input wire logic prescaler_in,
    output logic modulus_select,
    output logic modulus_control,
    output logic reference_phase_input,
    output logic divider_phase_input,
    output synth_core_pkg::tri_pin_t charge_pump,
    output synth_core_pkg::tri_pin_t switched_pump_out,
    output logic comparator_ref_out,
    output synth_core_pkg::tri_pin_t comparator_div,
    output logic monitor_out,
    output logic lock_indicator
);
    import synth_core_pkg::*;

    core_state_t st_reg;
    core_state_t st_next;

    // Sampled pin edges
    logic sclk_rise;
    logic osc_rise;
    logic fin_rise;

    // Fields unpacked from the shifter (destination bit) and the latches
    logic dest_high;
    logic ref_modulus;
    logic [REF_CNT_W-1:0] ref_ratio;
    logic [SWALLOW_W-1:0] swallow_ratio;
    logic [MAIN_CNT_W-1:0] main_ratio;

    // Divider events
    logic ref_terminal;
    logic main_terminal;
    logic swallow_done;
    logic ref_tick;
    logic div_tick;

    // Comparator pin decode
    logic pump_level;
    logic pump_drive;
    logic ref_drive;
    logic div_sink;
    logic locked;

    always_comb begin
        st_next = st_reg;
        sclk_rise = 1'b0;
        osc_rise = 1'b0;
        fin_rise = 1'b0;
        dest_high = 1'b0;
        ref_modulus = 1'b0;
        ref_ratio = 14'h0000;
        swallow_ratio = 7'h00;
        main_ratio = 11'h000;
        ref_terminal = 1'b0;
        main_terminal = 1'b0;
        swallow_done = 1'b0;
        ref_tick = 1'b0;
        div_tick = 1'b0;
        pump_level = 1'b0;
        pump_drive = 1'b0;
        ref_drive = 1'b0;
        div_sink = 1'b0;
        locked = 1'b1;

        // Previous samples reset low, matching the idle level of the pins
        sclk_rise = shift_clock & ~st_reg.sclk_prev_reg;
        osc_rise = osc_in & ~st_reg.osc_prev_reg;
        fin_rise = prescaler_in & ~st_reg.fin_prev_reg;
        st_next.sclk_prev_reg = shift_clock;
        st_next.osc_prev_reg = osc_in;
        st_next.fin_prev_reg = prescaler_in;

        // MSB first into bit 0; the low 16 bits double as the reference word
        if (sclk_rise) begin
            st_next.shift_reg = {st_reg.shift_reg[SHIFT_W-2:0], serial_data};
        end

        // Level-sensitive transfer: the latch follows the shifter while strobe is high or open
        dest_high = st_reg.shift_reg[DEST_POS];
        if (load_strobe) begin
            if (dest_high) begin
                st_next.ref_latch_reg = st_reg.shift_reg[REF_WORD_W-1:1];
            end else begin
                st_next.main_latch_reg = st_reg.shift_reg[SHIFT_W-1:1];
            end
        end

        // Counters read only the settled latches, never the shifter
        ref_modulus = st_reg.ref_latch_reg[LATCH_MOD_POS];
        ref_ratio = st_reg.ref_latch_reg[LATCH_REF_LSB +: REF_CNT_W];
        swallow_ratio = st_reg.main_latch_reg[LATCH_SWALLOW_LSB +: SWALLOW_W];
        main_ratio = st_reg.main_latch_reg[LATCH_MAIN_LSB +: MAIN_CNT_W];

        // Reference divider; a zero latch behaves as terminal every edge
        ref_terminal = st_reg.ref_cnt_reg <= 14'h0001;
        if (osc_rise) begin
            if (ref_terminal) begin
                ref_tick = 1'b1;
                st_next.ref_cnt_reg = ref_ratio;
            end else begin
                st_next.ref_cnt_reg = st_reg.ref_cnt_reg - 14'h0001;
            end
        end
        st_next.ref_tick_reg = ref_tick;

        // Pulse swallow: high modulus for A prescaler periods, low for N-A
        swallow_done = st_reg.swallow_cnt_reg == 7'h00;
        main_terminal = st_reg.main_cnt_reg <= 11'h001;
        if (fin_rise) begin
            if (!swallow_done) begin
                st_next.swallow_cnt_reg = st_reg.swallow_cnt_reg - 7'h01;
            end
            if (main_terminal) begin
                div_tick = 1'b1;
                st_next.main_cnt_reg = main_ratio;
                st_next.swallow_cnt_reg = swallow_ratio;
                st_next.modulus_reg = ref_modulus;
            end else begin
                st_next.main_cnt_reg = st_reg.main_cnt_reg - 11'h001;
            end
        end
        st_next.div_tick_reg = div_tick;

        // Phase-frequency detector: UP means reference leads
        case (st_reg.pfd_reg)
            PFD_IDLE: begin
                if (ref_tick & ~div_tick) begin
                    st_next.pfd_reg = PFD_UP;
                end else if (div_tick & ~ref_tick) begin
                    st_next.pfd_reg = PFD_DOWN;
                end
            end
            PFD_UP: begin
                if (div_tick & ~ref_tick) begin
                    st_next.pfd_reg = PFD_IDLE;
                end
            end
            PFD_DOWN: begin
                if (ref_tick & ~div_tick) begin
                    st_next.pfd_reg = PFD_IDLE;
                end
            end
            default: begin
                st_next.pfd_reg = PFD_IDLE;
            end
        endcase

        // One row per detector state; the sense input swaps the two leading rows
        case (st_next.pfd_reg)
            PFD_UP: begin
                if (phase_sense_select) begin
                    pump_level = 1'b1;
                    pump_drive = 1'b1;
                    ref_drive = 1'b0;
                    div_sink = 1'b1;
                end else begin
                    pump_level = 1'b0;
                    pump_drive = 1'b1;
                    ref_drive = 1'b1;
                    div_sink = 1'b0;
                end
                locked = 1'b0;
            end
            PFD_DOWN: begin
                if (phase_sense_select) begin
                    pump_level = 1'b0;
                    pump_drive = 1'b1;
                    ref_drive = 1'b1;
                    div_sink = 1'b0;
                end else begin
                    pump_level = 1'b1;
                    pump_drive = 1'b1;
                    ref_drive = 1'b0;
                    div_sink = 1'b1;
                end
                locked = 1'b0;
            end
            default: begin
                pump_level = 1'b0;
                pump_drive = 1'b0;
                ref_drive = 1'b0;
                div_sink = 1'b0;
                locked = 1'b1;
            end
        endcase

        st_next.pump_reg.out = pump_level;
        st_next.pump_reg.oe = pump_drive;
        st_next.comp_ref_reg = ref_drive;
        // Open drain: the sink can only pull low or let go
        st_next.comp_div_reg.out = 1'b0;
        st_next.comp_div_reg.oe = div_sink;
        // Switch follows the strobe level, so an open strobe keeps it closed
        st_next.switched_reg.out = pump_level;
        st_next.switched_reg.oe = load_strobe & pump_drive;
        st_next.lock_reg = locked;
        if (phase_sense_select) begin
            st_next.monitor_reg = ref_tick;
        end else begin
            st_next.monitor_reg = div_tick;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_reg.shift_reg <= SHIFT_RESET;
            st_reg.ref_latch_reg <= REF_LATCH_RESET;
            st_reg.main_latch_reg <= MAIN_LATCH_RESET;
            st_reg.sclk_prev_reg <= 1'b0;
            st_reg.osc_prev_reg <= 1'b0;
            st_reg.fin_prev_reg <= 1'b0;
            st_reg.ref_cnt_reg <= 14'h0000;
            st_reg.swallow_cnt_reg <= 7'h00;
            st_reg.main_cnt_reg <= 11'h000;
            st_reg.modulus_reg <= 1'b0;
            st_reg.ref_tick_reg <= 1'b0;
            st_reg.div_tick_reg <= 1'b0;
            st_reg.pfd_reg <= PFD_IDLE;
            st_reg.monitor_reg <= 1'b0;
            st_reg.lock_reg <= 1'b1;
            st_reg.pump_reg <= '0;
            st_reg.switched_reg <= '0;
            st_reg.comp_ref_reg <= 1'b0;
            st_reg.comp_div_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Prescaler sees ratio only via these; modulus_control high asks for P+1
    assign modulus_select = st_reg.modulus_reg;
    assign modulus_control = st_reg.swallow_cnt_reg != 7'h00;
    assign reference_phase_input = st_reg.ref_tick_reg;
    assign divider_phase_input = st_reg.div_tick_reg;
    assign charge_pump = st_reg.pump_reg;
    assign switched_pump_out = st_reg.switched_reg;
    assign comparator_ref_out = st_reg.comp_ref_reg;
    assign comparator_div = st_reg.comp_div_reg;
    assign monitor_out = st_reg.monitor_reg;
    assign lock_indicator = st_reg.lock_reg;

endmodule

/* File: include/synth_core_pkg.sv */
package synth_core_pkg;

    localparam int SHIFT_W = 19;
    localparam int REF_WORD_W = 16;
    localparam int REF_LATCH_W = 15;
    localparam int MAIN_LATCH_W = 18;
    localparam int REF_CNT_W = 14;
    localparam int SWALLOW_W = 7;
    localparam int MAIN_CNT_W = 11;

    // Word layout, bit 0 is the destination bit (last shifted in)
    localparam int DEST_POS = 0;
    localparam int REF_MOD_POS = 1;
    localparam int REF_CNT_LSB = 2;
    localparam int SWALLOW_LSB = 1;
    localparam int MAIN_CNT_LSB = 8;

    // Positions inside the latches (latch = word without destination bit)
    localparam int LATCH_MOD_POS = 0;
    localparam int LATCH_REF_LSB = 1;
    localparam int LATCH_SWALLOW_LSB = 0;
    localparam int LATCH_MAIN_LSB = 7;

    localparam logic [REF_LATCH_W-1:0] REF_LATCH_RESET = 15'h0000;
    localparam logic [MAIN_LATCH_W-1:0] MAIN_LATCH_RESET = 18'h00000;
    localparam logic [SHIFT_W-1:0] SHIFT_RESET = 19'h00000;

    typedef enum logic [2:0] {
        PFD_IDLE = 3'b001,
        PFD_UP = 3'b010,
        PFD_DOWN = 3'b100
    } pfd_state_t;

    typedef struct packed {
        logic out;
        logic oe;
    } tri_pin_t;

    typedef struct packed {
        logic [SHIFT_W-1:0] shift_reg;
        logic [REF_LATCH_W-1:0] ref_latch_reg;
        logic [MAIN_LATCH_W-1:0] main_latch_reg;
        logic sclk_prev_reg;
        logic osc_prev_reg;
        logic fin_prev_reg;
        logic [REF_CNT_W-1:0] ref_cnt_reg;
        logic [SWALLOW_W-1:0] swallow_cnt_reg;
        logic [MAIN_CNT_W-1:0] main_cnt_reg;
        logic modulus_reg;
        logic ref_tick_reg;
        logic div_tick_reg;
        pfd_state_t pfd_reg;
        logic monitor_reg;
        logic lock_reg;
        tri_pin_t pump_reg;
        tri_pin_t switched_reg;
        logic comp_ref_reg;
        tri_pin_t comp_div_reg;
    } core_state_t;

endpackage

/* File: verification/host_model.sv */
`timescale 1ns/1ps
module host_model (
    input wire logic ref_clk,
    output logic serial_data = 1'b0,
    output logic shift_clock = 1'b0,
    output logic load_strobe = 1'b0
);
    // Three lines only, word MSB first, destination bit last
    task automatic send(input logic [18:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge ref_clk);
            serial_data <= w[i];
            shift_clock <= 1'b1;
            @(posedge ref_clk);
            shift_clock <= 1'b0;
        end
        @(posedge ref_clk);
        load_strobe <= 1'b1;
        repeat (3) @(posedge ref_clk);
        load_strobe <= 1'b0;
        // Idle data flips so a stale bit never looks valid
        serial_data <= ~serial_data;
    endtask
    // Holds the strobe at a level for the switch tests
    task automatic set_strobe(input logic v);
        @(posedge ref_clk);
        load_strobe <= v;
    endtask
endmodule

/* File: verification/serial_pll_divider_core_asserts.sv */
`timescale 1ns/1ps
module serial_pll_divider_core_asserts (
    input wire logic ref_clk, reset, load_strobe, phase_sense_select, reference_phase_input,
    input wire logic divider_phase_input, comparator_ref_out, monitor_out, lock_indicator,
    input synth_core_pkg::tri_pin_t charge_pump, switched_pump_out, comparator_div
);
    import synth_core_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_switch_on; $past(load_strobe) && charge_pump.oe |-> switched_pump_out == charge_pump; endproperty
    a_switch_on: assert property (p_switch_on) else $error("switch not pump");
    property p_switch_off; !$past(load_strobe) |-> !switched_pump_out.oe; endproperty
    a_switch_off: assert property (p_switch_off) else $error("switch not released");
    property p_ref_lead; $stable(phase_sense_select) && reference_phase_input && !divider_phase_input
        && !lock_indicator |-> charge_pump.oe && (charge_pump.out == phase_sense_select); endproperty
    a_ref_lead: assert property (p_ref_lead) else $error("pump level after reference tick");
    property p_div_lead; $stable(phase_sense_select) && divider_phase_input && !reference_phase_input
        && !lock_indicator |-> charge_pump.oe && (charge_pump.out == !phase_sense_select); endproperty
    a_div_lead: assert property (p_div_lead) else $error("pump level after divider tick");
    property p_od; comparator_div.out == 1'b0; endproperty
    a_od: assert property (p_od) else $error("open drain high");
    property p_ref_drv; comparator_ref_out == (charge_pump.oe && !charge_pump.out); endproperty
    a_ref_drv: assert property (p_ref_drv) else $error("ref drive wrong");
    property p_div_drv; comparator_div.oe == (charge_pump.oe && charge_pump.out); endproperty
    a_div_drv: assert property (p_div_drv) else $error("div drive wrong");
    property p_lock; lock_indicator == !charge_pump.oe; endproperty
    a_lock: assert property (p_lock) else $error("lock wrong");
    property p_mon; $stable(phase_sense_select) |->
        monitor_out == (phase_sense_select ? reference_phase_input : divider_phase_input); endproperty
    a_mon: assert property (p_mon) else $error("monitor wrong");
    property p_rst; $fell(reset) |-> lock_indicator && !charge_pump.oe && !switched_pump_out.oe; endproperty
    a_rst: assert property (p_rst) else $error("not idle after reset");
endmodule
bind serial_pll_divider_core serial_pll_divider_core_asserts i_chk (.*);

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import synth_core_pkg::*;
    typedef struct {int r; logic mod_bit; int n; int a;} row_t;
    row_t rows [3] = '{'{8, 1'b1, 16, 0}, '{9, 1'b0, 17, 5}, '{12, 1'b1, 20, 15}};
    logic ref_clk = 1'b0, reset = 1'b1, phase_sense_select = 1'b1, osc_in = 1'b0, prescaler_in = 1'b0, ph = 1'b0;
    logic serial_data, shift_clock, load_strobe, modulus_select, modulus_control, reference_phase_input;
    logic divider_phase_input, comparator_ref_out, monitor_out, lock_indicator;
    tri_pin_t charge_pump, switched_pump_out, comparator_div;
    int fail_count = 0, n_checks = 0, ref_cnt = 0, ref_per = 0, div_cnt = 0, div_per = 0, hi = 0, hi_p = 0;
    always #10 ref_clk = ~ref_clk;
    host_model i_host (.*);
    serial_pll_divider_core i_dut (.*);
    // Both inputs rise every 4 cycles, so periods are 4 times the ratio
    always @(posedge ref_clk) begin
        ph <= ~ph;
        osc_in <= osc_in ^ ph;
        prescaler_in <= prescaler_in ^ ph;
        ref_cnt++;
        div_cnt++;
        if (reference_phase_input === 1'b1) {ref_per, ref_cnt} = {ref_cnt, 32'sd0};
        if (divider_phase_input === 1'b1) {div_per, div_cnt, hi_p, hi} = {div_cnt, 32'sd0, hi, 32'sd0};
        hi += int'(modulus_control === 1'b1);
    end
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %0d seen %0d", s, e, g);
        end
    endtask
    task automatic final_report;
        if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        foreach (rows[k]) begin
            i_host.send({3'h0, rows[k].r[13:0], rows[k].mod_bit, 1'b1}, 16);
            i_host.send({rows[k].n[10:0], rows[k].a[6:0], 1'b0}, 19);
            repeat (300) @(posedge ref_clk);
            chk("ref_period", 16'(4 * rows[k].r), ref_per[15:0]);
            chk("div_period", 16'(4 * rows[k].n), div_per[15:0]);
            chk("high_modulus", 16'(4 * rows[k].a), hi_p[15:0]);
            chk("modulus_select", 16'(rows[k].mod_bit), 16'(modulus_select));
        end
        phase_sense_select <= 1'b0;
        repeat (2) @(posedge ref_clk);
        repeat (100) begin
            @(posedge ref_clk);
            chk("monitor_out", 16'(divider_phase_input), 16'(monitor_out));
        end
        i_host.set_strobe(1'b1);
        repeat (2) @(posedge ref_clk);
        repeat (100) begin
            @(posedge ref_clk);
            chk("switched_out", 16'(charge_pump), 16'(switched_pump_out));
        end
        i_host.set_strobe(1'b0);
        repeat (2) @(posedge ref_clk);
        repeat (100) begin
            @(posedge ref_clk);
            chk("switched_oe", 16'h0000, 16'(switched_pump_out.oe));
        end
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        chk("lock_indicator", 16'h0001, 16'(lock_indicator));
        chk("pump_oe", 16'h0000, 16'(charge_pump.oe));
        chk("modulus_select", 16'h0000, 16'(modulus_select));
        final_report;
    end
    initial begin
        repeat (4000) @(posedge ref_clk);
        fail_count++;
        final_report;
    end
endmodule
